// ### mms_pkg.sv
// constants and types for the monitor mode entry and serial link block
package mms_pkg;
  // ----------------------------------------------------------------
  // clock and bit timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_HZ = 9600;
  localparam int unsigned BIT_CYC_PLL = CLK_HZ / BAUD_HZ;
  localparam logic [15:0] REF_DIV_CYC = 16'h0400;
  // ----------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------
  localparam logic [3:0] SEC_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [9:0] BREAK_FRAME = 10'h000;
  localparam logic [9:0] IDLE_FRAME = 10'h3ff;
  // sync bits: 0 irq high voltage, 1 reset high voltage, 2 irq level, 3 rx
  localparam logic [3:0] SYNC_RST = 4'h8;
  // ----------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_VEC_HI = 16'hfffe;
  localparam logic [15:0] RST_VEC_LO = 16'hffff;
  localparam logic [7:0] USER_VEC_PAGE = 8'hff;
  localparam logic [7:0] MON_VEC_PAGE = 8'hfe;
  localparam logic [7:0] VEC_LOW_MIN = 8'hfc;
  localparam logic [7:0] ERASED = 8'hff;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_USER = 2'b00,
    ST_SEC = 2'b01,
    ST_BRK = 2'b10,
    ST_CMD = 2'b11
  } mms_state_t;
  typedef struct packed {
    logic monitor;
    logic forced;
    logic pll_on;
    logic watchdog_en;
  } mms_mode_t;
endpackage

// ### mms_monitor_entry.sv
// monitor mode selection, vector remap, watchdog gate and host serial link
`timescale 1ns/10ps
`default_nettype none
// Contract
// - rx pin in, tx pin out always
// - wait for eight security bytes first
// - then send ten-bit low break
// - monitor vectors moved to fe page
// - watchdog off while high voltage present; user mode keeps it on
// - watchdog enabled once high voltage removed
// - low irq, programmed vector: user mode
// - erased reset vector fetch: internal reset
// - erased vector: forced monitor, watchdog off
// - non power-on reset keeps forced monitor
// - multiplied clock gives 9600 baud
// - irq low, erased: reference over 1024
// - nrz framing, equal tx/rx rates
// - echo each byte, result after echo; security bytes get no echo
// - eight byte match unlocks protected memory
module mms_monitor_entry
  import mms_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_PLL
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic por_n,
  // mode pins
  input wire logic irq_hi_test,
  input wire logic rst_hi_test,
  input wire logic irq_level,
  // serial pins
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  // reset vector fetch observation
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_data,
  // vector address steering
  input wire logic [15:0] vec_addr_in,
  output logic [15:0] vec_addr_out,
  // security
  input wire logic [63:0] sec_ref,
  output logic sec_ok,
  // byte stream to and from monitor firmware
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // mode status
  output mms_mode_t mode,
  output logic internal_rst_req
);
  function automatic logic is_vec(input logic [15:0] a);
    is_vec = (a[15:8] == USER_VEC_PAGE) && (a[7:0] >= VEC_LOW_MIN);
  endfunction

  logic [3:0] sync1_q, sync2_q;
  logic started_q, forced_q, div_q, sec_ok_q, hi_erased_q, irq_q;
  logic [7:0] rst_data_q;
  mms_mode_t mode_q;
  mms_state_t state_q;
  logic [15:0] bit_cyc, rx_cnt_q, tx_cnt_q;
  logic [3:0] rx_bit_q, tx_bit_q, sec_idx_q;
  logic [7:0] rx_sh_q, rx_byte_q, echo_q;
  logic [9:0] tx_sh_q;
  logic rx_busy_q, rx_done_q, tx_busy_q, echo_pend_q, sec_bad_q;
  logic rxd, hv, lo_erased, load_brk, load_echo, load_fw, sec_hit;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // no reset here: the chain keeps sampling while reset is held, so the
  // straps have already settled when the first edge after release reads them
  always_ff @(posedge core_clk) begin
    sync1_q <= {serial_receive_pin, irq_level, rst_hi_test, irq_hi_test};
    sync2_q <= sync1_q;
  end
  assign rxd = sync2_q[3];
  assign hv = sync2_q[0] | sync2_q[1];

  // ----------------------------------------------------------------
  // mode selection at reset release
  // ----------------------------------------------------------------
  // first edge after release samples the synchronised straps; the host
  // must hold them from before the release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      started_q <= 1'b0;
      mode_q <= '0;
    end else begin
      started_q <= 1'b1;
      if (!started_q) begin
        if (forced_q) begin
          mode_q <= '{1'b1, 1'b1, ~div_q, 1'b0};
        end else if (sync2_q[0] && rxd) begin
          mode_q <= '{1'b1, 1'b0, 1'b1, 1'b0};
        end else begin
          mode_q <= '{1'b0, 1'b0, 1'b1, 1'b1};
        end
      end else if (mode_q.monitor && !mode_q.forced) begin
        mode_q.watchdog_en <= ~hv;
      end
    end
  end
  assign mode = mode_q;

  // ----------------------------------------------------------------
  // erased reset vector watch
  // ----------------------------------------------------------------
  assign lo_erased = fetch_valid && (fetch_addr == RST_VEC_LO) &&
                     (fetch_data == ERASED) && hi_erased_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hi_erased_q <= 1'b0;
      internal_rst_req <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= sync2_q[2];
      internal_rst_req <= started_q && !mode_q.monitor && lo_erased;
      if (fetch_valid && fetch_addr == RST_VEC_HI) begin
        hi_erased_q <= (fetch_data == ERASED);
      end
    end
  end

  // forced state and security survive every reset but power-on
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      forced_q <= 1'b0;
      div_q <= 1'b0;
      sec_ok_q <= 1'b0;
    end else begin
      if (started_q && !mode_q.monitor && lo_erased) begin
        forced_q <= 1'b1;
        div_q <= ~irq_q;
      end
      if (sec_hit) begin
        sec_ok_q <= 1'b1;
      end
    end
  end
  assign sec_ok = sec_ok_q;

  // vector steering stays out of the clocked path so fetches see no lag
  assign vec_addr_out = (mode_q.monitor && is_vec(vec_addr_in)) ?
                        {MON_VEC_PAGE, vec_addr_in[7:0]} : vec_addr_in;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign bit_cyc = mode_q.pll_on ? BIT_CYC[15:0] : REF_DIV_CYC;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_byte_q <= '0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rxd && started_q && mode_q.monitor) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= {1'b0, bit_cyc[15:1]};
          rx_bit_q <= '0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= bit_cyc - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == '0 && rxd) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == FRAME_LAST) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= rxd;
          rx_byte_q <= rx_sh_q;
        end else if (rx_bit_q != '0) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        end
      end
    end
  end
  assign rx_data = rx_byte_q;
  assign rx_valid = rx_done_q && (state_q == ST_CMD);

  // ----------------------------------------------------------------
  // sequencer and security check
  // ----------------------------------------------------------------
  assign sec_hit = (state_q == ST_SEC) && rx_done_q && sec_idx_q == SEC_LAST &&
                   !sec_bad_q && rx_byte_q == sec_ref[{sec_idx_q[2:0], 3'b000} +: 8];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_USER;
      sec_idx_q <= '0;
      sec_bad_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_USER: begin
          if (started_q && mode_q.monitor) begin
            state_q <= ST_SEC;
          end
        end
        ST_SEC: begin
          if (rx_done_q) begin
            sec_idx_q <= sec_idx_q + 4'h1;
            if (rx_byte_q != sec_ref[{sec_idx_q[2:0], 3'b000} +: 8]) begin
              sec_bad_q <= 1'b1;
            end
            if (sec_idx_q == SEC_LAST) begin
              state_q <= ST_BRK;
            end
          end
        end
        ST_BRK: begin
          if (!tx_busy_q) begin
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          state_q <= ST_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitter: break, then echoes ahead of firmware results
  // ----------------------------------------------------------------
  assign load_brk = (state_q == ST_BRK) && !tx_busy_q;
  assign load_echo = (state_q == ST_CMD) && !tx_busy_q && echo_pend_q;
  assign tx_ready = (state_q == ST_CMD) && !tx_busy_q && !echo_pend_q &&
                    !rx_done_q;
  assign load_fw = tx_valid && tx_ready;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      echo_pend_q <= 1'b0;
      echo_q <= '0;
    end else begin
      if ((state_q == ST_CMD) && rx_done_q) begin
        echo_pend_q <= 1'b1;
        echo_q <= rx_byte_q;
      end else if (load_echo) begin
        echo_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= IDLE_FRAME;
    end else if (load_brk || load_echo || load_fw) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= bit_cyc - 16'h0001;
      tx_bit_q <= FRAME_LAST;
      if (load_brk) begin
        tx_sh_q <= BREAK_FRAME;
      end else begin
        tx_sh_q <= {1'b1, load_echo ? echo_q : tx_data, 1'b0};
      end
    end else if (tx_busy_q) begin
      if (tx_cnt_q != '0) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else if (tx_bit_q == '0) begin
        tx_busy_q <= 1'b0;
        tx_sh_q <= IDLE_FRAME;
      end else begin
        tx_cnt_q <= bit_cyc - 16'h0001;
        tx_bit_q <= tx_bit_q - 4'h1;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      end
    end
  end
  assign serial_transmit_pin = tx_sh_q[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence brk_start_s;
    load_brk;
  endsequence
  sequence line_low_s;
    !serial_transmit_pin [*8];
  endsequence

  sec_quiet_a: assert property ((state_q == ST_SEC) |->
    serial_transmit_pin && !rx_valid) else $error("link active early");
  break_low_a: assert property (brk_start_s |=> line_low_s)
    else $error("break not low");
  vec_remap_a: assert property (mode_q.monitor &&
    vec_addr_in == RST_VEC_HI |-> vec_addr_out == 16'hfefe)
    else $error("reset vector not remapped");
  wdog_hold_a: assert property (started_q && mode_q.monitor && hv
    |=> !mode_q.watchdog_en) else $error("watchdog on under high voltage");
  wdog_release_a: assert property (started_q && mode_q.monitor &&
    !mode_q.forced && !hv |=> mode_q.watchdog_en)
    else $error("watchdog not enabled");
  user_wdog_a: assert property (started_q && !mode_q.monitor
    |-> mode_q.watchdog_en) else $error("user mode without watchdog");
  erase_rst_a: assert property (started_q && !mode_q.monitor &&
    lo_erased |=> internal_rst_req && forced_q)
    else $error("erased vector missed");
  forced_entry_a: assert property (!started_q && forced_q |=>
    mode_q.monitor && mode_q.forced && !mode_q.watchdog_en)
    else $error("forced monitor not entered");
  echo_first_a: assert property ((state_q == ST_CMD) && rx_done_q
    |=> echo_pend_q && !tx_ready) else $error("echo not queued");
  sec_unlock_a: assert property (sec_hit |=> sec_ok)
    else $error("matching key did not unlock");
endmodule
`default_nettype wire

// ### mms_host_model.sv
// behavioural host computer on the two-wire monitor link
`timescale 1ns/10ps
`default_nettype none
module mms_host_model #(
  parameter int unsigned BIT_CYC = 16
) (
  // bit pacing clock
  input wire logic core_clk,
  // link lines
  input wire logic rx_line,
  output logic tx_line,
  // received frame report, stop bit on top
  output logic got,
  output logic [8:0] got_frame
);
  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  // mark level at rest doubles as the monitor entry strap at reset
  initial tx_line = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      tx_line = fr[i];
      repeat (BIT_CYC - 1) @(negedge core_clk);
    end
  endtask
  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  initial begin
    got = 1'b0;
    got_frame = 9'h000;
    forever begin
      @(negedge core_clk iff rx_line === 1'b0);
      repeat (BIT_CYC / 2) @(negedge core_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(negedge core_clk);
        got_frame[i] = rx_line;
      end
      got = 1'b1;
      @(negedge core_clk);
      got = 1'b0;
      // a break stays low past its stop sample, so wait for mark first
      @(negedge core_clk iff rx_line === 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the monitor entry and serial link block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mms_pkg::*;
  localparam int BC = 16;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic por_n = 1'b0;
  logic irq_hi_test = 1'b0;
  logic rst_hi_test = 1'b0;
  logic irq_level = 1'b1;
  logic fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0] fetch_data = 8'h00;
  logic [15:0] vec_addr_in = 16'h0000;
  logic [63:0] sec_ref = 64'h0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic irq_seen = 1'b0;
  logic rx_pin, tx_pin, sec_ok, rx_valid, tx_ready, host_got;
  logic internal_rst_req;
  logic [15:0] vec_addr_out;
  logic [7:0] rx_data;
  logic [8:0] host_frame;
  mms_mode_t mode;
  logic [8:0] exp_q[$];
  logic [7:0] exp_rx[$];
  int n_fail = 0;
  int cmp_count = 0;

  mms_monitor_entry #(.BIT_CYC(BC)) DUT (.core_clk(core_clk),
    .resetn(resetn), .por_n(por_n), .irq_hi_test(irq_hi_test),
    .rst_hi_test(rst_hi_test), .irq_level(irq_level),
    .serial_receive_pin(rx_pin), .serial_transmit_pin(tx_pin),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .vec_addr_in(vec_addr_in),
    .vec_addr_out(vec_addr_out), .sec_ref(sec_ref), .sec_ok(sec_ok),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .mode(mode),
    .internal_rst_req(internal_rst_req));
  mms_host_model #(.BIT_CYC(BC)) host (.core_clk(core_clk),
    .rx_line(tx_pin), .tx_line(rx_pin), .got(host_got),
    .got_frame(host_frame));

  initial forever #5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string name);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic rst(input logic por);
    @(negedge core_clk);
    resetn = 1'b0;
    por_n = ~por;
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    por_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic fetch_erased();
    @(negedge core_clk);
    fetch_valid = 1'b1;
    fetch_addr = RST_VEC_HI;
    fetch_data = ERASED;
    @(negedge core_clk);
    fetch_addr = RST_VEC_LO;
    @(negedge core_clk);
    fetch_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    check(16'(irq_seen), 16'h0001, "int_rst");
    irq_seen = 1'b0;
  endtask

  task automatic fw_send(input logic [7:0] b);
    @(negedge core_clk);
    tx_data = b;
    tx_valid = 1'b1;
    @(posedge core_clk iff tx_ready === 1'b1);
    @(negedge core_clk);
    tx_valid = 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() > 0 || exp_rx.size() > 0) && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    // room for any stray frame to show up before moving on
    repeat (12 * BC) @(negedge core_clk);
    check(16'(exp_q.size() + exp_rx.size()), 16'h0000, "pending");
  endtask

  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  always @(posedge core_clk)
    if (internal_rst_req === 1'b1) irq_seen <= 1'b1;
  always @(posedge host_got)
    check(16'(host_frame), exp_q.size() > 0 ? 16'(exp_q.pop_front()) :
          16'hffff, "tx_frame");
  always @(posedge core_clk)
    if (rx_valid === 1'b1)
      check(16'(rx_data), exp_rx.size() > 0 ? 16'(exp_rx.pop_front()) :
            16'hffff, "rx_data");

  initial begin
    #(600_000);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [7:0] b, r;
    void'($urandom(32'hfb67));
    sec_ref = {$urandom, $urandom};
    rst(1'b1);
    check(16'(mode), 16'h0003, "mode");
    vec_addr_in = RST_VEC_HI;
    #1 check(vec_addr_out, RST_VEC_HI, "vec");
    fetch_erased();
    rst(1'b0);
    check(16'(mode), 16'h000e, "mode");
    for (int k = 0; k < 4; k++) begin
      vec_addr_in = 16'hfffc + 16'(k);
      #1 check(vec_addr_out, 16'hfefc + 16'(k), "vec");
    end
    exp_q.push_back(9'h000);
    for (int i = 0; i < 8; i++) host.send(sec_ref[8*i +: 8]);
    drain();
    check(16'(sec_ok), 16'h0001, "sec_ok");
    for (int j = 0; j < 4; j++) begin
      b = 8'($urandom);
      r = 8'($urandom);
      exp_rx.push_back(b);
      exp_q.push_back({1'b1, b});
      exp_q.push_back({1'b1, r});
      host.send(b);
      fw_send(r);
    end
    drain();
    rst(1'b0);
    check(16'(mode), 16'h000e, "mode");
    irq_hi_test = 1'b1;
    rst(1'b1);
    check(16'(mode), 16'h000a, "mode");
    rst_hi_test = 1'b1;
    irq_hi_test = 1'b0;
    repeat (5) @(negedge core_clk);
    check(16'(mode), 16'h000a, "mode");
    rst_hi_test = 1'b0;
    repeat (5) @(negedge core_clk);
    check(16'(mode), 16'h000b, "mode");
    exp_q.push_back(9'h000);
    for (int i = 0; i < 8; i++) host.send(~sec_ref[8*i +: 8]);
    drain();
    check(16'(sec_ok), 16'h0000, "sec_ok");
    irq_level = 1'b0;
    rst(1'b1);
    fetch_erased();
    rst(1'b0);
    check(16'(mode), 16'h000c, "mode");
    end_sim();
  end
endmodule
`default_nettype wire
